// ### rtl/ppb_config_space.sv
// Contract
// (RQ1) byte offset is address bits [7:2] with two zero bits appended
// (RQ2) offset zero reads part identifier high half, maker identifier low half
// (RQ3) status bit 30 sets on graphics port error forwarded; write one clears
// (RQ4) status bits 31,29,28,27,24,23,22,20 always read zero
// (RQ5) select timing field bits 26-25 reads binary 01
// (RQ6) status bit 21 always reads one
// (RQ7) command bits 9,7,6,5,4,3 always read zero
// (RQ8) bit 8 gates OR of port error and own error onto system error
// (RQ9) graphics port memory accesses accepted only while bit 2 set
// (RQ10) bit 1 enables forwarding memory accesses inside memory window
// (RQ11) bit 0 enables forwarding I/O accesses inside I/O window
// (RQ12) class reads 06h, 04h, 00h
// (RQ13) class bits 7-0 hold read-only silicon revision
// (RQ14) header type reads 0x01 with bit 23 zero
// (RQ15) primary latency timer is storage only
// (RQ16) secondary latency timer read/write, secondary mastering only
// (RQ17) type 1 cycles within secondary..subordinate are passed on
// (RQ18) type 1 cycle to secondary bus becomes type 0
// (RQ19) primary bus number flags secondary type 1 as special cycle
// (RQ20) I/O base and limit upper nibbles writable, low nibbles read one
// (RQ21) software numbers primary bus 0, graphics bus 1
// (RQ22) memory windows 1 Mbyte granular, limit low bits all ones
// (RQ23) upper I/O register zero disables forwarding above 16 bits
// (RQ24) reserved reads zero, writes to read-only ignored
// (RQ25) writing zero leaves sticky status; set holds until cleared
`timescale 1ns/100ps
`include "ppb_defines.svh"

module ppb_config_space import ppb_pkg::*; #(
   parameter logic [15:0] PART_ID = 16'h1234,  // arbitrary value
   parameter logic [15:0] MAKER_ID = 16'h5678, // arbitrary value
   parameter logic [7:0] REVISION = 8'h01      // arbitrary value
) (
   input wire logic core_clk,               // core clock
   input wire logic sys_rst,                // synchronous reset, high
   input wire logic clk_en,                 // freezes state when low
   input wire ppb_cfg_req_t cfg_req,        // configuration access
   output logic [31:0] cfg_rdata,           // read data, one cycle later
   output logic cfg_rvalid,                 // read data valid pulse
   input wire logic graphics_port_error_in, // port error pin, high
   input wire logic own_error_in,           // internal primary error
   output logic sys_error_out,              // error to peripheral controller
   input wire ppb_fwd_req_t fwd_req,        // processor access to decode
   output logic fwd_hit,                    // forward onto graphics port
   input wire logic dma_req,                // graphics port memory request
   output logic dma_accept,                 // request accepted
   input wire logic t1_valid,               // primary type 1 cycle
   input wire logic [7:0] t1_bus,           // its target bus number
   output ppb_t1_act_t t1_action,           // claim action
   input wire logic sec_t1_valid,           // secondary type 1 cycle
   input wire logic [7:0] sec_t1_bus,       // its target bus number
   output logic special_cycle,              // convert to special cycle
   output logic [7:0] sec_lat_timer         // secondary latency timer
);

   // ****************************************
   // pin synchronisers
   // ****************************************
   logic gerr_s1_q, gerr_s2_q;
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         gerr_s1_q <= 1'b0;
         gerr_s2_q <= 1'b0;
      end else if (clk_en) begin
         gerr_s1_q <= graphics_port_error_in;
         gerr_s2_q <= gerr_s1_q;
      end
   end

   // ****************************************
   // register storage
   // ****************************************
   logic [15:0] cmd_q;
   logic syserr_q;
   logic [7:0] pri_lat_q, pri_bus_q, sec_bus_q, sub_bus_q, sec_lat_q;
   logic [3:0] io_base_q, io_lim_q;
   logic [11:0] mem_base_q, mem_lim_q, pf_base_q, pf_lim_q;
   logic [7:0] io_base_up_q, io_lim_up_q;
   logic [31:0] brctl_q, misc_q;

   wire [7:0] ofs = {cfg_req.addr[7:2], 2'b00}; // see RQ1
   wire wr = cfg_req.wr;
   wire [31:0] wd = cfg_req.wdata;
   wire err_event = cmd_q[`PPB_CMD_SERR_EN] & gerr_s2_q;
   wire clr_syserr = wr && ofs == `PPB_OFS_CMDSTAT && wd[`PPB_ST_SYSERR];

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cmd_q <= 16'h0000;
         syserr_q <= 1'b0;
         pri_lat_q <= `PPB_RST_BYTE;
         pri_bus_q <= `PPB_RST_BYTE;
         sec_bus_q <= `PPB_RST_BYTE;
         sub_bus_q <= `PPB_RST_BYTE;
         sec_lat_q <= `PPB_RST_BYTE;
         io_base_q <= 4'h0;
         io_lim_q <= 4'h0;
         mem_base_q <= 12'h000;
         mem_lim_q <= 12'h000;
         pf_base_q <= 12'h000;
         pf_lim_q <= 12'h000;
         io_base_up_q <= `PPB_RST_BYTE;
         io_lim_up_q <= `PPB_RST_BYTE;
         brctl_q <= `PPB_RST_WORD;
         misc_q <= `PPB_RST_WORD;
      end else if (clk_en) begin
         // set wins over clear
         if (err_event)
            syserr_q <= 1'b1; // see RQ3
         else if (clr_syserr)
            syserr_q <= 1'b0; // see RQ25
         if (wr) begin
            unique case (ofs)
               `PPB_OFS_CMDSTAT: cmd_q <= wd[15:0] & `PPB_CMD_WMASK; // see RQ7
               `PPB_OFS_HDR: pri_lat_q <= wd[15:8]; // see RQ15
               `PPB_OFS_BUSNUM: begin
                  pri_bus_q <= wd[7:0];
                  sec_bus_q <= wd[15:8];
                  sub_bus_q <= wd[23:16];
                  sec_lat_q <= wd[31:24]; // see RQ16
               end
               `PPB_OFS_IOWIN: begin
                  io_base_q <= wd[7:4]; // see RQ20
                  io_lim_q <= wd[15:12];
               end
               `PPB_OFS_MEMWIN: begin
                  mem_base_q <= wd[15:4];
                  mem_lim_q <= wd[31:20];
               end
               `PPB_OFS_PFWIN: begin
                  pf_base_q <= wd[15:4];
                  pf_lim_q <= wd[31:20];
               end
               `PPB_OFS_IOUP: begin
                  io_base_up_q <= wd[7:0];
                  io_lim_up_q <= wd[23:16];
               end
               `PPB_OFS_BRCTL: brctl_q <= {8'h00, 3'b000, wd[20:16], wd[15:0]};
               `PPB_OFS_MISC: misc_q <= wd;
               default: ; // see RQ24
            endcase
         end
      end
   end

   // ****************************************
   // read decode
   // ****************************************
   wire [15:0] status_w = {1'b0, syserr_q, 3'b000, `PPB_ST_SELTIM, 3'b000,
                           1'b1, 1'b0, 4'h0}; // see RQ4 see RQ5 see RQ6
   wire [15:0] sec_status_w = {1'b0, syserr_q, 3'b000, `PPB_ST_SELTIM, 3'b000,
                               1'b1, 1'b0, 4'h0};
   logic [31:0] rd_mux;
   always_comb begin
      unique case (ofs)
         `PPB_OFS_IDENT: rd_mux = {PART_ID, MAKER_ID}; // see RQ2
         `PPB_OFS_CMDSTAT: rd_mux = {status_w, cmd_q};
         `PPB_OFS_CLASS: rd_mux = {`PPB_CLASS_CODE, REVISION}; // see RQ12 see RQ13
         `PPB_OFS_HDR: rd_mux = {8'h00, `PPB_HDR_TYPE, pri_lat_q, 8'h00}; // see RQ14
         `PPB_OFS_BUSNUM: rd_mux = {sec_lat_q, sub_bus_q, sec_bus_q, pri_bus_q};
         `PPB_OFS_IOWIN: rd_mux = {sec_status_w, io_lim_q, `PPB_IO_CAP,
                                   io_base_q, `PPB_IO_CAP}; // see RQ20
         `PPB_OFS_MEMWIN: rd_mux = {mem_lim_q, 4'h0, mem_base_q, 4'h0};
         `PPB_OFS_PFWIN: rd_mux = {pf_lim_q, 4'h0, pf_base_q, 4'h0};
         `PPB_OFS_IOUP: rd_mux = {8'h00, io_lim_up_q, 8'h00, io_base_up_q};
         `PPB_OFS_BRCTL: rd_mux = brctl_q;
         `PPB_OFS_MISC: rd_mux = misc_q;
         default: rd_mux = `PPB_RST_WORD; // see RQ24
      endcase
   end

   // ****************************************
   // forwarding and claim decode
   // ****************************************
   wire [31:0] a = fwd_req.addr;
   wire [31:0] mb = {mem_base_q, 20'h00000}; // see RQ22
   wire [31:0] ml = {mem_lim_q, `PPB_MEM_LOW_ONES};
   wire [31:0] pb = {pf_base_q, 20'h00000};
   wire [31:0] pl = {pf_lim_q, `PPB_MEM_LOW_ONES};
   wire mem_hit = (a >= mb && a <= ml) || (a >= pb && a <= pl);
   wire [31:0] ib = {8'h00, io_base_up_q, io_base_q, 12'h000};
   wire [31:0] il = {8'h00, io_lim_up_q, io_lim_q, 12'hFFF};
   // upper half zero keeps the window below 64K, see RQ23
   wire io_hit = a[31:24] == 8'h00 && a >= ib && a <= il;
   wire hit_d = (fwd_req.mem && cmd_q[`PPB_CMD_MEM] && mem_hit)  // see RQ10
              || (fwd_req.io && cmd_q[`PPB_CMD_IO] && io_hit);   // see RQ11
   ppb_t1_act_t t1_d;
   assign t1_d = !t1_valid ? PPB_T1_IGNORE :
                 t1_bus == sec_bus_q ? PPB_T1_TO_T0 :                   // see RQ18
                 (t1_bus > sec_bus_q && t1_bus <= sub_bus_q) ? PPB_T1_PASS : // see RQ17
                 PPB_T1_IGNORE;
   wire serr_d = cmd_q[`PPB_CMD_SERR_EN] & (gerr_s2_q | own_error_in); // see RQ8

   // ****************************************
   // registered outputs
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cfg_rdata <= `PPB_RST_WORD;
         cfg_rvalid <= 1'b0;
         sys_error_out <= 1'b0;
         fwd_hit <= 1'b0;
         dma_accept <= 1'b0;
         t1_action <= PPB_T1_IGNORE;
         special_cycle <= 1'b0;
         sec_lat_timer <= `PPB_RST_BYTE;
      end else if (clk_en) begin
         cfg_rvalid <= cfg_req.rd;
         if (cfg_req.rd)
            cfg_rdata <= rd_mux;
         sys_error_out <= serr_d;
         fwd_hit <= hit_d;
         dma_accept <= dma_req & cmd_q[`PPB_CMD_INITIATOR_ENABLE]; // see RQ9
         t1_action <= t1_d;
         special_cycle <= sec_t1_valid && sec_t1_bus == pri_bus_q; // see RQ19
         sec_lat_timer <= sec_lat_q;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   serr_gate_a: assert property (@(posedge core_clk) disable iff (sys_rst) // see RQ8
      clk_en && !cmd_q[`PPB_CMD_SERR_EN] |=> !sys_error_out)
      else $error("system error driven while disabled");
   syserr_set_a: assert property (@(posedge core_clk) disable iff (sys_rst) // see RQ3
      clk_en && err_event |=> syserr_q)
      else $error("system error status not set");
   syserr_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst) // see RQ25
      syserr_q && !clr_syserr |=> syserr_q)
      else $error("system error status lost");
   dma_gate_a: assert property (@(posedge core_clk) disable iff (sys_rst) // see RQ9
      dma_accept |-> $past(cmd_q[`PPB_CMD_INITIATOR_ENABLE]))
      else $error("dma accepted while master disabled");
   cmd_zero_a: assert property (@(posedge core_clk) disable iff (sys_rst) // see RQ7
      (cmd_q & ~`PPB_CMD_WMASK) == 16'h0000)
      else $error("fixed command bits set");
   fwd_mem_a: assert property (@(posedge core_clk) disable iff (sys_rst) // see RQ10
      clk_en && fwd_req.mem && !fwd_req.io && !cmd_q[`PPB_CMD_MEM] |=> !fwd_hit)
      else $error("memory forwarded while disabled");
   t1_conv_a: assert property (@(posedge core_clk) disable iff (sys_rst) // see RQ18
      clk_en && t1_valid && t1_bus == sec_bus_q |=> t1_action == PPB_T1_TO_T0)
      else $error("type 1 not converted");
   status_fix_a: assert property (@(posedge core_clk) disable iff (sys_rst) // see RQ5
      status_w[10:9] == `PPB_ST_SELTIM && status_w[5] && !status_w[15])
      else $error("fixed status bits wrong");
   rd_valid_a: assert property (@(posedge core_clk) disable iff (sys_rst) // see RQ24
      clk_en && cfg_req.rd && ofs == 8'h14 |=> cfg_rvalid && cfg_rdata == 32'h0)
      else $error("reserved offset read nonzero");

endmodule

// ### rtl/ppb_defines.svh
`ifndef PPB_DEFINES_SVH
`define PPB_DEFINES_SVH

// ****************************************
// register offsets
// ****************************************
`define PPB_OFS_IDENT 8'h00
`define PPB_OFS_CMDSTAT 8'h04
`define PPB_OFS_CLASS 8'h08
`define PPB_OFS_HDR 8'h0C
`define PPB_OFS_BUSNUM 8'h18
`define PPB_OFS_IOWIN 8'h1C
`define PPB_OFS_MEMWIN 8'h20
`define PPB_OFS_PFWIN 8'h24
`define PPB_OFS_IOUP 8'h30
`define PPB_OFS_BRCTL 8'h3C
`define PPB_OFS_MISC 8'h40

// ****************************************
// field positions and constant values
// ****************************************
`define PPB_ST_SYSERR 30
`define PPB_CMD_SERR_EN 8
`define PPB_CMD_INITIATOR_ENABLE 2
`define PPB_CMD_MEM 1
`define PPB_CMD_IO 0
`define PPB_CMD_WMASK 16'h0107
`define PPB_ST_SELTIM 2'h1
`define PPB_CLASS_CODE 24'h060400
`define PPB_HDR_TYPE 8'h01
`define PPB_IO_CAP 4'h1
`define PPB_MEM_LOW_ONES 20'hFFFFF
`define PPB_RST_BYTE 8'h00
`define PPB_RST_WORD 32'h00000000

`endif

// ### rtl/ppb_pkg.sv
package ppb_pkg;

   // configuration request from the host side
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [31:0] addr;
      logic [31:0] wdata;
   } ppb_cfg_req_t;

   // address to be decoded against the forwarding windows
   typedef struct packed {
      logic        mem;
      logic        io;
      logic [31:0] addr;
   } ppb_fwd_req_t;

   typedef enum logic [1:0] {
      PPB_T1_IGNORE = 2'b00,
      PPB_T1_PASS = 2'b01,
      PPB_T1_TO_T0 = 2'b10
   } ppb_t1_act_t;

endpackage

// ### test/ppb_gfx_model.sv
`timescale 1ns/100ps
// ****
// graphics controller side
// ****
module ppb_gfx_model (
   input wire logic core_clk, // core clock
   output logic port_err,     // error pin toward bridge
   output logic dma_req       // memory request toward bridge
);
   initial begin
      port_err = 1'b0;
      dma_req = 1'b0;
   end
   // error pin held for n edges, dropped just after the last one
   task automatic raise_err(input int n);
      port_err = 1'b1;
      repeat (n) @(posedge core_clk);
      #1 port_err = 1'b0;
   endtask
   task automatic set_dma(input logic v);
      dma_req = v;
   endtask
endmodule

// ### test/tb.sv
`timescale 1ns/100ps
// ****
// bench
// ****
module tb import ppb_pkg::*;;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic clk_en = 1'b1;
   ppb_cfg_req_t req = '0;
   ppb_fwd_req_t fwd = '0;
   logic own_err = 1'b0;
   logic t1_v = 1'b0;
   logic [7:0] t1_b = 8'h00;
   logic st1_v = 1'b0;
   logic [7:0] st1_b = 8'h00;
   logic [31:0] cfg_rdata;
   logic cfg_rvalid, sys_err, fwd_hit, dma_req, dma_acc, port_err, spc;
   ppb_t1_act_t t1_act;
   logic [7:0] slat;
   int err_total = 0;
   int compares = 0;
   logic [63:0] rows [10] = '{64'h00000103_12345678, 64'h00000004_02200000,
      64'h00000008_06040001, 64'h0000000C_00010000, 64'h00000018_00000000,
      64'h0000001C_02200101, 64'h00000020_00000000, 64'h00000014_00000000,
      64'h00000044_00000000, 64'h000000FC_00000000};
   logic [34:0] frows [8] = '{{3'h5, 32'h00003FFF}, {3'h1, 32'h00004000},
      {3'h1, 32'h00001FFF}, {3'h5, 32'h00002000}, {3'h6, 32'h100FFFFF},
      {3'h2, 32'h10100000}, {3'h6, 32'h10000000}, {3'h2, 32'h0FFFFFFF}};
   logic [9:0] trows [4] = '{{8'h01, 2'h2}, {8'h02, 2'h1}, {8'h03, 2'h1}, {8'h04, 2'h0}};
   initial begin
      forever #20 core_clk = ~core_clk;
   end
   ppb_config_space DUT (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .cfg_req(req), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
      .graphics_port_error_in(port_err), .own_error_in(own_err),
      .sys_error_out(sys_err), .fwd_req(fwd), .fwd_hit(fwd_hit), .dma_req(dma_req),
      .dma_accept(dma_acc), .t1_valid(t1_v), .t1_bus(t1_b), .t1_action(t1_act),
      .sec_t1_valid(st1_v), .sec_t1_bus(st1_b), .special_cycle(spc),
      .sec_lat_timer(slat));
   ppb_gfx_model gfx (.core_clk(core_clk), .port_err(port_err), .dma_req(dma_req));
   task automatic conclude;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic tick;
      @(posedge core_clk);
      #1;
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      int n;
      n = 0;
      req.rd = 1'b1;
      req.addr = a;
      tick();
      req.rd = 1'b0;
      while (cfg_rvalid !== 1'b1 && n < 3) begin
         tick();
         n++;
      end
      chk(32'(cfg_rvalid), 32'h1);
      if (cfg_rvalid !== 1'b1) conclude();
      chk(cfg_rdata, e);
      tick();
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      req.wr = 1'b1;
      req.addr = a;
      req.wdata = d;
      tick();
      req.wr = 1'b0;
      tick();
   endtask
   initial begin
      repeat (6) @(posedge core_clk);
      #1 sys_rst = 1'b0;
      foreach (rows[i]) rd(rows[i][63:32], rows[i][31:0]);
      $display("reset values done");
      wr(32'h04, 32'hFFFFFFFF);
      rd(32'h04, 32'h02200107);
      wr(32'h0C, 32'hFFFFFFFF);
      rd(32'h0C, 32'h0001FF00);
      gfx.raise_err(4);
      chk(32'(sys_err), 32'h1);
      rd(32'h04, 32'h42200107);
      wr(32'h04, 32'h00000107);
      rd(32'h04, 32'h42200107);
      wr(32'h04, 32'h40000107);
      rd(32'h04, 32'h02200107);
      own_err = 1'b1;
      tick();
      chk(32'(sys_err), 32'h1);
      wr(32'h04, 32'h00000007);
      chk(32'(sys_err), 32'h0);
      own_err = 1'b0;
      $display("error path done");
      wr(32'h18, 32'h40030100);
      chk(32'(slat), 32'h40);
      wr(32'h1C, 32'h00003020);
      rd(32'h1C, 32'h02203121);
      wr(32'h20, 32'h10001000);
      foreach (frows[i]) begin
         fwd = frows[i][33:0];
         tick();
         chk(32'(fwd_hit), 32'(frows[i][34]));
      end
      t1_v = 1'b1;
      foreach (trows[i]) begin
         t1_b = trows[i][9:2];
         tick();
         chk(32'(t1_act), 32'(trows[i][1:0]));
      end
      st1_v = 1'b1;
      tick();
      chk(32'(spc), 32'h1);
      st1_b = 8'h01;
      tick();
      chk(32'(spc), 32'h0);
      gfx.set_dma(1'b1);
      tick();
      chk(32'(dma_acc), 32'h1);
      $display("decode done");
      wr(32'h04, 32'h00000000);
      chk(32'(dma_acc), 32'h0);
      fwd = frows[0][33:0];
      tick();
      chk(32'(fwd_hit), 32'h0);
      fwd = frows[4][33:0];
      tick();
      chk(32'(fwd_hit), 32'h0);
      $display("enable gating done");
      clk_en = 1'b0;
      wr(32'h0C, 32'h00000000);
      clk_en = 1'b1;
      rd(32'h0C, 32'h0001FF00);
      sys_rst = 1'b1;
      tick();
      sys_rst = 1'b0;
      rd(32'h04, 32'h02200000);
      rd(32'h0C, 32'h00010000);
      $display("freeze and reset done");
      conclude();
   end
endmodule
